// ==== include/cssp_pkg.sv ====
// Package: constants and types for the serial slave pointer block
package cssp_pkg;
  localparam logic [3:0] ADDR_PATTERN   = 4'hA;
  localparam logic [7:0] CMD_BLOCK_WR   = 8'hC0;
  localparam logic [7:0] CMD_BLOCK_RD   = 8'hC1;
  localparam logic [7:0] CMD_REBOOT     = 8'hC4;
  localparam logic [7:0] REG_FIRST      = 8'h00;
  localparam logic [7:0] REG_LAST       = 8'h2F;
  localparam logic [7:0] USR_FIRST      = 8'h40;
  localparam logic [7:0] USR_LAST       = 8'h7F;
  localparam logic [7:0] CEE_FIRST      = 8'h80;
  localparam logic [7:0] CEE_LAST       = 8'hB7;
  localparam logic [7:0] CEE_MEANINGFUL = 8'hAE;
  localparam logic [7:0] BLOCK_COUNT    = 8'h10;
  localparam logic [7:0] PTR_RESET      = 8'h00;
  localparam int CLK_PERIOD_NS          = 10;
  localparam int CFG_LATENCY_NS         = 5000;
  localparam int THR_LATENCY_NS         = 150000;
  // Shorter configuration time counts one cycle less
  localparam int CFG_LATENCY_CYC        = CFG_LATENCY_NS / CLK_PERIOD_NS - 1;
  localparam int THR_LATENCY_CYC        = THR_LATENCY_NS / CLK_PERIOD_NS;
  localparam logic [5:0] DL_WORDS       = 6'h30;
  localparam logic [7:0] THR_REG_LAST   = 8'h07;
  typedef enum logic [3:0] {
    CSSP_IDLE    = 4'h0,
    CSSP_DEVADR  = 4'h1,
    CSSP_CMD     = 4'h2,
    CSSP_COUNT   = 4'h3,
    CSSP_WDATA   = 4'h4,
    CSSP_RDATA   = 4'h5,
    CSSP_RACK    = 4'h6,
    CSSP_IGNORE  = 4'h7
  } cssp_state_type;
endpackage

// ==== include/cssp_byte_if.sv ====
// Interface: byte stream between the core and the two-entry buffer
`timescale 1ns/10ps
interface cssp_byte_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== hdl/cssp_skid.sv ====
// Two-entry buffer on the read data path
`timescale 1ns/10ps
module cssp_skid #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic  clk,
  input  wire logic  rstn,
  input  wire logic  flush,
  cssp_byte_if.snk   up,
  cssp_byte_if.src   dn
);
  logic [WIDTH-1:0]         mem_reg [DEPTH];
  logic [$clog2(DEPTH):0]   cnt_reg;
  logic [$clog2(DEPTH)-1:0] wp_reg;
  logic [$clog2(DEPTH)-1:0] rp_reg;
  logic                     push;
  logic                     pop;

  assign up.ready = (cnt_reg != DEPTH[$clog2(DEPTH):0]);
  assign dn.valid = (cnt_reg != '0);
  assign dn.data  = mem_reg[rp_reg];
  assign push     = up.valid && up.ready;
  assign pop      = dn.valid && dn.ready;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_reg <= '0;
      wp_reg  <= '0;
      rp_reg  <= '0;
    end
    else if (flush)
    begin
      cnt_reg <= '0;
      wp_reg  <= '0;
      rp_reg  <= '0;
    end
    else
    begin
      if (push)
        wp_reg <= wp_reg + 1'b1;
      if (pop)
        rp_reg <= rp_reg + 1'b1;
      if (push && !pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wp_reg] <= up.data;
  end
endmodule // cssp_skid

// ==== hdl/cssp_bit_sync.sv ====
// Two-flop synchroniser with edge and condition detection for the bus pins
`timescale 1ns/10ps
module cssp_bit_sync (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det,
  output logic      sda_s
);
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end

  assign sda_s     = sda_d_reg;
  assign scl_rise  = scl_sync_reg[1] && !scl_d_reg;
  assign scl_fall  = !scl_sync_reg[1] && scl_d_reg;
  // Conditions only while the clock line stays high
  assign start_det = scl_sync_reg[1] && scl_d_reg
                     && !sda_sync_reg[1] && sda_d_reg;
  assign stop_det  = scl_sync_reg[1] && scl_d_reg
                     && sda_sync_reg[1] && !sda_d_reg;
endmodule // cssp_bit_sync

// ==== hdl/cssp_core.sv ====
// Serial slave front end with pointer, memory spaces and boot download
`timescale 1ns/10ps
module cssp_core #(
  parameter int THR_CYC = cssp_pkg::THR_LATENCY_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        addr_select_low_pin,
  input  wire logic        addr_select_high_pin,
  input  wire logic        supply_lockout_threshold,
  output logic             download_busy,
  output logic [8*48-1:0]  programmable_output
);
  cssp_pkg::cssp_state_type state_reg;
  logic [7:0]  cfg_reg  [48];
  logic [7:0]  act_reg  [48];
  logic [7:0]  ee_reg   [128];
  logic [7:0]  ptr_reg;
  logic [7:0]  shift_reg;
  logic [3:0]  bit_reg;
  logic        ack_reg;
  logic        drive_reg;
  logic        is_cmd_reg;
  logic        blkrd_reg;
  logic        blkwr_reg;
  logic        cnt_sent_reg;
  logic [4:0]  left_reg;
  logic        lock_s1_reg;
  logic        lock_s2_reg;
  logic        dl_reg;
  logic [5:0]  dl_idx_reg;
  logic [5:0]  lat_idx_reg;
  // Counter must hold the longer of the two latencies
  localparam int LAT_MAX = (THR_CYC > cssp_pkg::CFG_LATENCY_CYC)
                           ? THR_CYC : cssp_pkg::CFG_LATENCY_CYC;
  logic [$clog2(LAT_MAX+1)-1:0] lat_cnt_reg;
  logic        lat_pend_reg;
  logic        scl_rise, scl_fall, start_det, stop_det, sda_s;
  logic        flush;
  cssp_byte_if rd_if ();
  cssp_byte_if tx_if ();

  cssp_bit_sync u_sync (
    .clk       (clk),
    .rstn      (rstn),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det),
    .sda_s     (sda_s)
  );

  cssp_skid #(.WIDTH(8), .DEPTH(2)) u_buf (
    .clk   (clk),
    .rstn  (rstn),
    .flush (flush),
    .up    (rd_if),
    .dn    (tx_if)
  );

  function automatic logic ptr_legal(input logic [7:0] p);
    ptr_legal = (p <= cssp_pkg::REG_LAST)
             || (p >= cssp_pkg::USR_FIRST && p <= cssp_pkg::USR_LAST)
             || (p >= cssp_pkg::CEE_FIRST && p <= cssp_pkg::CEE_LAST);
  endfunction

  function automatic logic at_boundary(input logic [7:0] p);
    at_boundary = (p == cssp_pkg::REG_LAST) || (p == cssp_pkg::USR_LAST)
               || (p == cssp_pkg::CEE_LAST);
  endfunction

  function automatic logic [7:0] mem_read(input logic [7:0] p);
    if (p <= cssp_pkg::REG_LAST)
      mem_read = cfg_reg[p[5:0]];
    else if (p >= cssp_pkg::USR_FIRST && p <= cssp_pkg::CEE_LAST)
      mem_read = ee_reg[p[6:0] ^ 7'h40];
    else
      mem_read = 8'h00;
  endfunction

  wire logic busy = dl_reg;
  assign flush    = start_det || stop_det;
  assign download_busy = dl_reg;

  // Read side of the buffer: block count pushed, never popped since tx_if.ready is tied low
  assign rd_if.valid = (state_reg == cssp_pkg::CSSP_RDATA)
                       && blkrd_reg && !cnt_sent_reg;
  assign rd_if.data  = cssp_pkg::BLOCK_COUNT;
  assign tx_if.ready = 1'b0;

  // Supply lockout crosses from a pin: two flops before use
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
    end
    else
    begin
      lock_s1_reg <= supply_lockout_threshold;
      lock_s2_reg <= lock_s1_reg;
    end
  end

  // Download copies configuration EEPROM into the registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dl_reg     <= 1'b1;
      dl_idx_reg <= '0;
    end
    else if (state_reg == cssp_pkg::CSSP_CMD && bit_reg == 4'h8
             && scl_fall && shift_reg == cssp_pkg::CMD_REBOOT && !busy)
    begin
      dl_reg     <= 1'b1;
      dl_idx_reg <= '0;
    end
    else if (dl_reg && lock_s2_reg)
    begin
      if (dl_idx_reg == cssp_pkg::DL_WORDS - 6'h01)
        dl_reg <= 1'b0;
      dl_idx_reg <= dl_idx_reg + 6'h01;
    end
  end

  // Active copy lags configuration by the latency period
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lat_pend_reg <= 1'b0;
      lat_cnt_reg  <= '0;
      lat_idx_reg  <= '0;
    end
    else if (state_reg == cssp_pkg::CSSP_WDATA && bit_reg == 4'h8
             && scl_fall && ptr_reg <= cssp_pkg::REG_LAST)
    begin
      lat_pend_reg <= 1'b1;
      lat_idx_reg  <= ptr_reg[5:0];
      lat_cnt_reg  <= (ptr_reg <= cssp_pkg::THR_REG_LAST)
                      ? $bits(lat_cnt_reg)'(THR_CYC)
                      : $bits(lat_cnt_reg)'(cssp_pkg::CFG_LATENCY_CYC);
    end
    else if (lat_pend_reg)
    begin
      if (lat_cnt_reg == '0)
        lat_pend_reg <= 1'b0;
      else
        lat_cnt_reg <= lat_cnt_reg - 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 48; gi++)
    begin : g_act
      always_ff @(posedge clk)
      begin
        if (dl_reg || (lat_pend_reg && lat_cnt_reg == '0
                       && lat_idx_reg == 6'(gi)))
          act_reg[gi] <= cfg_reg[gi];
      end
      assign programmable_output[8*gi +: 8] = act_reg[gi];
    end
  endgenerate

  // Memory writes: download into registers, serial data into spaces
  always_ff @(posedge clk)
  begin
    if (dl_reg && lock_s2_reg)
      cfg_reg[dl_idx_reg] <= ee_reg[{1'b1, dl_idx_reg}];
    else if (state_reg == cssp_pkg::CSSP_WDATA && bit_reg == 4'h8
             && scl_fall)
    begin
      if (ptr_reg < cssp_pkg::REG_LAST)
        cfg_reg[ptr_reg[5:0]] <= shift_reg;
      else if (ptr_reg >= cssp_pkg::USR_FIRST && ptr_reg <= cssp_pkg::CEE_LAST)
        ee_reg[ptr_reg[6:0] ^ 7'h40] <= shift_reg;
    end
  end

  // Protocol engine
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg    <= cssp_pkg::CSSP_IDLE;
      ptr_reg      <= cssp_pkg::PTR_RESET;
      shift_reg    <= 8'h00;
      bit_reg      <= 4'h0;
      ack_reg      <= 1'b0;
      drive_reg    <= 1'b0;
      blkrd_reg    <= 1'b0;
      blkwr_reg    <= 1'b0;
      cnt_sent_reg <= 1'b0;
      left_reg     <= 5'h00;
    end
    else if (stop_det)
    begin
      state_reg <= cssp_pkg::CSSP_IDLE;
      drive_reg <= 1'b0;
      blkwr_reg <= 1'b0;
      blkrd_reg <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg <= cssp_pkg::CSSP_DEVADR;
      bit_reg   <= 4'h0;
      drive_reg <= 1'b0;
    end
    else if (scl_rise && bit_reg < 4'h8)
    begin
      // Transmit byte shifts on the falling edge only
      if (state_reg != cssp_pkg::CSSP_RDATA)
        shift_reg <= {shift_reg[6:0], sda_s};
      bit_reg   <= bit_reg + 4'h1;
    end
    else if (scl_rise && bit_reg == 4'h8)
    begin
      bit_reg <= 4'h9;
      unique case (state_reg)
        cssp_pkg::CSSP_RDATA:
          // Own address acknowledge is not a completed read
          if (!ack_reg)
          begin
            if (sda_s || (blkrd_reg && cnt_sent_reg && left_reg == 5'h01))
              state_reg <= cssp_pkg::CSSP_IGNORE;
            if (!blkrd_reg || cnt_sent_reg)
            begin
              if (!at_boundary(ptr_reg))
                ptr_reg <= ptr_reg + 8'h01;
              left_reg <= left_reg - 5'h01;
            end
            cnt_sent_reg <= 1'b1;
          end
        default:
        begin
        end
      endcase
    end
    else if (scl_fall && bit_reg == 4'h8)
    begin
      // Decide acknowledge for the byte just received
      drive_reg <= 1'b0;
      ack_reg   <= 1'b0;
      unique case (state_reg)
        cssp_pkg::CSSP_DEVADR:
          if (shift_reg[7:4] == cssp_pkg::ADDR_PATTERN
              && shift_reg[3] == addr_select_high_pin
              && shift_reg[2] == addr_select_low_pin && !busy)
          begin
            ack_reg   <= 1'b1;
            drive_reg <= 1'b1;
            state_reg <= shift_reg[0] ? cssp_pkg::CSSP_RDATA
                                      : cssp_pkg::CSSP_CMD;
            cnt_sent_reg <= 1'b0;
            left_reg  <= 5'h10;
          end
          else
            state_reg <= cssp_pkg::CSSP_IGNORE;
        cssp_pkg::CSSP_CMD:
          if (busy)
            state_reg <= cssp_pkg::CSSP_IGNORE;
          else if (shift_reg == cssp_pkg::CMD_BLOCK_RD)
          begin
            ack_reg <= 1'b1; drive_reg <= 1'b1;
            blkrd_reg <= 1'b1;
            state_reg <= cssp_pkg::CSSP_IGNORE;
          end
          else if (shift_reg == cssp_pkg::CMD_BLOCK_WR)
          begin
            ack_reg <= 1'b1; drive_reg <= 1'b1;
            blkwr_reg <= 1'b1;
            state_reg <= cssp_pkg::CSSP_COUNT;
          end
          else if (shift_reg == cssp_pkg::CMD_REBOOT)
            state_reg <= cssp_pkg::CSSP_IGNORE;
          else if (ptr_legal(shift_reg))
          begin
            ack_reg <= 1'b1; drive_reg <= 1'b1;
            ptr_reg <= shift_reg;
            state_reg <= cssp_pkg::CSSP_WDATA;
            blkrd_reg <= 1'b0;
          end
          else
            state_reg <= cssp_pkg::CSSP_IGNORE;
        cssp_pkg::CSSP_COUNT:
        begin
          ack_reg <= 1'b1; drive_reg <= 1'b1;
          left_reg  <= shift_reg[4:0];
          state_reg <= cssp_pkg::CSSP_WDATA;
        end
        cssp_pkg::CSSP_WDATA:
        begin
          ack_reg <= 1'b1; drive_reg <= 1'b1;
          if (!blkwr_reg || left_reg != 5'h00)
          begin
            if (!at_boundary(ptr_reg))
              ptr_reg <= ptr_reg + 8'h01;
            left_reg <= left_reg - 5'h01;
          end
        end
        default:
        begin
        end
      endcase
    end
    else if (scl_fall && bit_reg == 4'h9)
    begin
      // Load next transmit byte or release the line
      bit_reg <= (state_reg == cssp_pkg::CSSP_RDATA) ? 4'h0 : 4'h0;
      if (state_reg == cssp_pkg::CSSP_RDATA)
      begin
        shift_reg <= (blkrd_reg && !cnt_sent_reg)
                     ? cssp_pkg::BLOCK_COUNT : mem_read(ptr_reg);
        drive_reg <= 1'b1;
      end
      else
        drive_reg <= 1'b0;
      ack_reg <= 1'b0;
    end
    else if (scl_fall && state_reg == cssp_pkg::CSSP_RDATA && bit_reg < 4'h8)
    begin
      shift_reg <= {shift_reg[6:0], 1'b1};
      drive_reg <= 1'b1;
    end
  end

  // Transmit shifts MSB first; a high bit releases the open-drain line
  assign sda_oe  = drive_reg && (ack_reg || (state_reg
                   == cssp_pkg::CSSP_RDATA && !shift_reg[7]));
  assign sda_out = 1'b0;

  a_nack_busy: assert property (@(posedge clk) disable iff (!rstn)
    dl_reg |-> !(ack_reg && drive_reg))
    else $error("acknowledge driven during download");
  a_ptr_stable: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == cssp_pkg::CSSP_IGNORE && !blkrd_reg && $stable(state_reg))
    |-> $stable(ptr_reg))
    else $error("pointer moved after nack");
  a_ptr_legal: assert property (@(posedge clk) disable iff (!rstn)
    ptr_legal(ptr_reg))
    else $error("pointer outside legal spaces");
  a_ptr_hold: assert property (@(posedge clk) disable iff (!rstn)
    (at_boundary(ptr_reg) && !(state_reg == cssp_pkg::CSSP_CMD)) |=>
    (ptr_reg == $past(ptr_reg) || $past(state_reg) == cssp_pkg::CSSP_CMD))
    else $error("pointer left boundary");
  a_stop_release: assert property (@(posedge clk) disable iff (!rstn)
    stop_det |=> !drive_reg)
    else $error("data still driven after stop");
  a_idle_release: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == cssp_pkg::CSSP_IDLE) |-> !sda_oe)
    else $error("data line pulled while bus idle");
endmodule // cssp_core

// ==== bench/cssp_master_model.sv ====
// Two-wire bus master model that drives the clock and data lines
`timescale 1ns/10ps
module cssp_master_model (
  output logic       scl,
  output logic       sda_pull,
  input  wire logic  sda_line,
  output logic       res_stb,
  output logic [8:0] res_val
);
  real q;

  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
    res_stb  = 1'b0;
    res_val  = 9'h000;
    q        = 31.25;
  end

  // Slow mode doubles every phase; the slave cannot stretch the clock
  task automatic set_slow(input bit s);
    q = s ? 62.5 : 31.25;
  endtask

  // Data changes only while the clock is low
  task automatic bit_io(input bit b, output bit r);
    #(q) sda_pull = ~b;
    #(q) scl = 1'b1;
    #(q) r = sda_line;
    #(q) scl = 1'b0;
  endtask

  task automatic report(input logic [8:0] v);
    res_val = v;
    res_stb = 1'b1;
    #1 res_stb = 1'b0;
  endtask

  // Also serves as repeated start from the low clock phase
  task automatic start();
    if (scl === 1'b0)
    begin
      #(q) sda_pull = 1'b0;
      #(q) scl = 1'b1;
    end
    #(q) sda_pull = 1'b1;
    #(q) scl = 1'b0;
  endtask

  task automatic stop();
    #(q) sda_pull = 1'b1;
    #(q) scl = 1'b1;
    #(q) sda_pull = 1'b0;
    #(q);
  endtask

  // MSB first, ninth bit is the slave's answer
  task automatic send_byte(input logic [7:0] b);
    bit r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    report({1'b1, 7'h00, ~r});
  endtask

  task automatic recv_byte(input bit last);
    bit         r;
    logic [7:0] d;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
    report({1'b0, d});
  endtask
endmodule // cssp_master_model

// ==== bench/cssp_core_tb_top.sv ====
// Testbench for the serial slave front end with pointer and download
`timescale 1ns/10ps
module cssp_core_tb_top;
  logic         clk;
  logic         rstn;
  logic         scl;
  logic         sda_pull;
  wire          sda_line;
  logic         sda_out;
  logic         sda_oe;
  logic         a_lo;
  logic         a_hi;
  logic         dcb;
  logic         lockout;
  logic         busy;
  logic [383:0] po;
  logic         res_stb;
  logic [8:0]   res_val;
  logic [8:0]   expq[$];
  logic [31:0]  seed;
  int           err_total;
  int           n_tests;

  // Pull-up wire: high unless someone pulls it low
  assign sda_line = ~(sda_pull | sda_oe);

  cssp_core #(.THR_CYC(200)) cssp_core_inst (
    .clk                      (clk),
    .rstn                     (rstn),
    .scl_in                   (scl),
    .sda_in                   (sda_line),
    .sda_out                  (sda_out),
    .sda_oe                   (sda_oe),
    .addr_select_low_pin      (a_lo),
    .addr_select_high_pin     (a_hi),
    .supply_lockout_threshold (lockout),
    .download_busy            (busy),
    .programmable_output      (po)
  );

  cssp_master_model cssp_master_model_inst (
    .scl      (scl),
    .sda_pull (sda_pull),
    .sda_line (sda_line),
    .res_stb  (res_stb),
    .res_val  (res_val)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Each answer seen by the master is matched with the oldest note
  always @(posedge res_stb)
  begin
    n_tests++;
    if (expq.size() == 0 || res_val !== expq[0])
    begin
      err_total++;
      $display("CHECK FAILED %0t bus result %h", $time, res_val);
    end
    if (expq.size() != 0)
      void'(expq.pop_front());
  end

  function automatic logic [7:0] adr(input logic rw);
    return {cssp_pkg::ADDR_PATTERN, a_hi, a_lo, dcb, rw};
  endfunction

  task automatic wb(input logic [7:0] b, input logic ack);
    expq.push_back({1'b1, 7'h00, ack});
    cssp_master_model_inst.send_byte(b);
  endtask

  task automatic rb(input logic [7:0] d, input bit last);
    expq.push_back({1'b0, d});
    cssp_master_model_inst.recv_byte(last);
  endtask

  task automatic set_ptr(input logic [7:0] p, input logic ack);
    cssp_master_model_inst.start();
    wb(adr(1'b0), 1'b1);
    wb(p, ack);
    cssp_master_model_inst.stop();
  endtask

  task automatic wr_byte(input logic [7:0] p, input logic [7:0] d);
    cssp_master_model_inst.start();
    wb(adr(1'b0), 1'b1);
    wb(p, 1'b1);
    wb(d, 1'b1);
    cssp_master_model_inst.stop();
  endtask

  task automatic rd_byte(input logic [7:0] p, input logic [7:0] d);
    cssp_master_model_inst.start();
    wb(adr(1'b0), 1'b1);
    wb(p, 1'b1);
    cssp_master_model_inst.start();
    wb(adr(1'b1), 1'b1);
    rb(d, 1'b1);
    cssp_master_model_inst.stop();
  endtask

  task automatic blk_wr(input logic [7:0] p, input logic [23:0] d);
    set_ptr(p, 1'b1);
    cssp_master_model_inst.start();
    wb(adr(1'b0), 1'b1);
    wb(cssp_pkg::CMD_BLOCK_WR, 1'b1);
    wb(8'h03, 1'b1);
    for (int i = 2; i >= 0; i--)
      wb(d[8*i+:8], 1'b1);
    cssp_master_model_inst.stop();
  endtask

  // Read the count and one byte, or two when n > 1, then end with a master answer
  task automatic blk_rd(input logic [7:0] d0, input logic [7:0] d1, int n);
    cssp_master_model_inst.start();
    wb(adr(1'b0), 1'b1);
    wb(cssp_pkg::CMD_BLOCK_RD, 1'b1);
    cssp_master_model_inst.start();
    wb(adr(1'b1), 1'b1);
    rb(cssp_pkg::BLOCK_COUNT, 1'b0);
    rb(d0, n == 1);
    if (n > 1)
      rb(d1, 1'b1);
    cssp_master_model_inst.stop();
  endtask

  task automatic po_chk(input int n, input logic [7:0] e);
    n_tests++;
    if (po[8*n+:8] !== e || busy !== 1'b0)
    begin
      err_total++;
      $display("CHECK FAILED %0t output byte %0d", $time, n);
    end
  endtask

  logic [7:0] ptab[8] = '{8'h2F, 8'h30, 8'h3F, 8'h40,
                          8'h7F, 8'h80, 8'hB7, 8'hB8};
  logic       atab[8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

  initial
  begin
    logic [7:0] ud[4];
    logic [7:0] v;
    logic [7:0] w;
    int         k;
    err_total = 0;
    n_tests   = 0;
    seed      = 32'h00000520;
    rstn      = 1'b0;
    lockout   = 1'b0;
    a_lo      = rnd() > 8'h7F;
    a_hi      = rnd() > 8'h7F;
    dcb       = rnd() > 8'h7F;
    for (int i = 0; i < 4; i++)
      ud[i] = rnd();
    v = rnd();
    w = rnd();
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (10) @(negedge clk);
    cssp_master_model_inst.start();
    wb(adr(1'b0), 1'b0);
    cssp_master_model_inst.stop();
    @(negedge clk);
    lockout = 1'b1;
    for (k = 0; k < 300 && busy !== 1'b0; k++)
      @(negedge clk);
    if (k == 300)
    begin
      err_total++;
      $display("CHECK FAILED %0t download never ends", $time);
      complete_run();
    end
    cssp_master_model_inst.start();
    wb(adr(1'b0) ^ 8'h10, 1'b0);
    cssp_master_model_inst.stop();
    for (int i = 0; i < 8; i++)
      set_ptr(ptab[i], atab[i]);
    wr_byte(8'h40, ud[0]);
    wr_byte(8'h41, ud[1]);
    rd_byte(8'h40, ud[0]);
    set_ptr(8'hB8, 1'b0);
    blk_rd(ud[1], ud[1], 1);
    blk_wr(8'h7E, {ud[2], ud[3], ud[0]});
    rd_byte(8'h7E, ud[2]);
    rd_byte(8'h7F, ud[0]);
    cssp_master_model_inst.set_slow(1'b1);
    blk_rd(ud[0], ud[0], 2);
    cssp_master_model_inst.set_slow(1'b0);
    blk_wr(8'hB6, {ud[1], ud[2], ud[3]});
    rd_byte(8'hB7, ud[3]);
    blk_wr(8'h2E, {ud[3], ud[1], ud[2]});
    rd_byte(8'h2E, ud[3]);
    wr_byte(8'h80, v);
    cssp_master_model_inst.start();
    wb(adr(1'b0), 1'b1);
    wb(cssp_pkg::CMD_REBOOT, 1'b0);
    cssp_master_model_inst.stop();
    repeat (300) @(negedge clk);
    po_chk(0, v);
    wr_byte(8'h00, ~v);
    po_chk(0, v);
    repeat (250) @(negedge clk);
    po_chk(0, ~v);
    wr_byte(8'h08, w);
    repeat (cssp_pkg::CFG_LATENCY_CYC) @(negedge clk);
    po_chk(8, w);
    wr_byte(8'h80, w);
    repeat (300) @(negedge clk);
    po_chk(0, ~v);
    repeat (20) @(negedge clk);
    n_tests++;
    if (expq.size() != 0)
    begin
      err_total++;
      $display("CHECK FAILED %0t bus answers missing", $time);
    end
    complete_run();
  end
endmodule // cssp_core_tb_top
